/* File: shared/serial_host_pkg.sv */
`default_nettype none
package serial_host_pkg;

  typedef enum logic [1:0] {
    MODE_I2C_SLAVE = 2'h0,
    MODE_SPI_SLAVE = 2'h1,
    MODE_SPI_MASTER = 2'h2,
    MODE_UNUSED = 2'h3
  } host_mode_e;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;

  // slave-side command bytes
  localparam logic [7:0] SLV_CMD_WRITE = 8'h02;
  localparam logic [7:0] SLV_CMD_READ = 8'h03;
  // byte shifted out when the core has not answered a read in time
  localparam logic [7:0] SLV_STALE_BYTE = 8'hFF;

  // eeprom read: command byte then 16-bit start address
  localparam logic [7:0] EE_CMD_READ = 8'h03;
  localparam logic [15:0] EE_START_ADDR = 16'h0000;
  localparam int EE_HDR_BITS = 24;
  localparam int CFG_BYTES_DEF = 16;

  localparam int CORE_CLK_MHZ = 200;
  localparam int EE_SCLK_PERIOD_NS = 100;
  // least period, so each half rounds up to whole core cycles
  localparam int EE_SCLK_HALF_CYC = (EE_SCLK_PERIOD_NS * CORE_CLK_MHZ + 1999) / 2000;

endpackage
`default_nettype wire

/* File: core/bit_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_ff, s2_ff;
  logic [W-1:0] nxt_s1, nxt_s2;

  always_comb begin
    nxt_s1 = rst_i ? '0 : d_i;
    nxt_s2 = rst_i ? '0 : s1_ff;
  end

  always_ff @(posedge clk_i) begin
    s1_ff <= nxt_s1;
    s2_ff <= nxt_s2;
  end

  assign q_o = s2_ff;

endmodule
`default_nettype wire

/* File: core/eeprom_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module eeprom_loader
  import serial_host_pkg::*;
#(
  parameter int CFG_BYTES = CFG_BYTES_DEF,
  parameter int HALF_CYC = EE_SCLK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic active_o,
  output logic done_o,
  output logic wr_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [BYTE_W-1:0] wr_data_o
);

  localparam int TOTAL_BITS = EE_HDR_BITS + CFG_BYTES * BYTE_W;
  localparam int CNT_W = $clog2(TOTAL_BITS + 1);
  localparam int DIV_W = $clog2(HALF_CYC + 1);

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_SHIFT = 2'b01,
    LD_DONE = 2'b11
  } load_state_e;

  load_state_e state_ff, nxt_state;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic [CNT_W-1:0] bits_ff, nxt_bits;
  logic sclk_ff, nxt_sclk;
  logic [EE_HDR_BITS-1:0] tx_sr_ff, nxt_tx_sr;
  logic [BYTE_W-1:0] rx_sr_ff, nxt_rx_sr, rx_byte;
  logic wr_ff, nxt_wr;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [BYTE_W-1:0] wr_data_ff, nxt_wr_data;
  logic half_end;

  always_comb begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_bits = bits_ff;
    nxt_sclk = sclk_ff;
    nxt_tx_sr = tx_sr_ff;
    nxt_rx_sr = rx_sr_ff;
    nxt_wr = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    rx_byte = {rx_sr_ff[BYTE_W-2:0], miso_i};
    half_end = (div_ff == DIV_W'(HALF_CYC - 1));
    if (rst_i) begin
      nxt_state = LD_IDLE;
      nxt_sclk = 1'b0;
      nxt_div = '0;
      nxt_bits = '0;
    end else begin
      unique case (state_ff)
        LD_IDLE: begin
          if (start_i) begin
            nxt_state = LD_SHIFT;
            nxt_tx_sr = {EE_CMD_READ, EE_START_ADDR}; // [R12]
            nxt_div = '0;
            nxt_bits = '0;
            nxt_sclk = 1'b0;
          end
        end
        LD_SHIFT: begin
          nxt_div = half_end ? '0 : div_ff + DIV_W'(1);
          if (half_end) begin
            nxt_sclk = ~sclk_ff; // [R11]
            if (sclk_ff) begin
              // synced miso lags the pin by two cycles, still inside the high half
              nxt_rx_sr = rx_byte; // [R13]
              nxt_tx_sr = {tx_sr_ff[EE_HDR_BITS-2:0], 1'b0}; // [R12]
              nxt_bits = bits_ff + CNT_W'(1);
              // header is a whole number of bytes, so low bits give byte phase
              if (bits_ff >= CNT_W'(EE_HDR_BITS) && bits_ff[2:0] == 3'h7) begin
                nxt_wr = 1'b1;
                nxt_wr_data = rx_byte;
                nxt_wr_addr = ADDR_W'((bits_ff - CNT_W'(EE_HDR_BITS)) >> 3);
              end
              if (bits_ff == CNT_W'(TOTAL_BITS - 1)) begin
                nxt_state = LD_DONE; // [R10]
              end
            end
          end
        end
        LD_DONE: nxt_state = LD_DONE;
        default: nxt_state = LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    state_ff <= nxt_state;
    div_ff <= nxt_div;
    bits_ff <= nxt_bits;
    sclk_ff <= nxt_sclk;
    tx_sr_ff <= nxt_tx_sr;
    rx_sr_ff <= nxt_rx_sr;
    wr_ff <= nxt_wr;
    wr_addr_ff <= nxt_wr_addr;
    wr_data_ff <= nxt_wr_data;
  end

  assign active_o = (state_ff == LD_SHIFT);
  assign cs_n_o = (state_ff != LD_SHIFT); // [R9]
  assign done_o = (state_ff == LD_DONE);
  assign sclk_o = sclk_ff;
  assign mosi_o = tx_sr_ff[EE_HDR_BITS-1];
  assign wr_o = wr_ff;
  assign wr_addr_o = wr_addr_ff;
  assign wr_data_o = wr_data_ff;

endmodule
`default_nettype wire

/* File: core/serial_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] both select pins are caught at device reset release and pick the mode
// [R2] after reset the low select pin is the active-low chip select
// [R3] after reset the high select pin is the MISO data line
// [R4] external master pulls chip select low for any register access
// [R5] external master supplies serial clock; device takes it as input
// [R6] external master shifts command, then address, then write data on MOSI
// [R7] as SPI slave the device drives read data on MISO
// [R8] as I2C slave the device only receives the serial clock
// [R9] as SPI master the device pulls chip select low for the eeprom
// [R10] after autoconfig the device releases chip select as an input
// [R11] as SPI master the device drives the serial clock out
// [R12] as SPI master the device sends command and address on MOSI
// [R13] as SPI master the device captures eeprom data from MISO
// [R14] after autoconfig clock and MOSI are released and slave mode serves
module serial_host_port
  import serial_host_pkg::*;
#(
  parameter int CFG_BYTES = CFG_BYTES_DEF,
  parameter int SCLK_HALF_CYC = EE_SCLK_HALF_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_sclk_i,
  input wire logic device_reset_n_i,
  input wire logic csn_i,
  output logic csn_o,
  output logic csn_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [BYTE_W-1:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  input wire logic [BYTE_W-1:0] reg_rdata_i,
  output host_mode_e mode_o,
  output logic mode_valid_o,
  output logic cfg_done_o
);

  typedef enum logic [1:0] {
    PS_HOLD = 2'b00,
    PS_LOAD = 2'b01,
    PS_SERVE = 2'b11,
    PS_PASSIVE = 2'b10
  } port_state_e;

  typedef enum logic [2:0] {
    LS_CMD = 3'b000,
    LS_ADDR_HI = 3'b001,
    LS_ADDR_LO = 3'b011,
    LS_DUMMY = 3'b010,
    LS_DATA = 3'b110,
    LS_SKIP = 3'b100
  } link_state_e;

  // link-domain registers that the core samples after a toggle, and the two-stage sync of the core's ack toggle
  logic slv_wr_tog_ff, nxt_wr_tog;
  logic slv_rd_tog_ff, nxt_rd_tog;
  logic [ADDR_W-1:0] slv_wr_addr_ff, nxt_wr_addr;
  logic [ADDR_W-1:0] slv_rd_addr_ff, nxt_rd_addr;
  logic [BYTE_W-1:0] slv_wr_data_ff, nxt_wr_data;
  logic ack_s1_ff, nxt_ack_s1;
  logic ack_s2_ff, nxt_ack_s2;

  // core-domain state
  port_state_e state_ff, nxt_state;
  host_mode_e mode_ff, nxt_mode;
  logic device_reset_n_prev_ff;
  logic link_rst_ff, slave_en_ff;
  logic load_start_ff, nxt_load_start;
  logic wr_seen_ff, nxt_wr_seen;
  logic rd_seen_ff, nxt_rd_seen;
  logic ack_tog_ff, nxt_ack_tog;
  logic [BYTE_W-1:0] rd_data_ff, nxt_rd_data;
  logic [ADDR_W-1:0] reg_addr_ff, nxt_reg_addr;
  logic [BYTE_W-1:0] reg_wdata_ff, nxt_reg_wdata;
  logic reg_we_ff, nxt_reg_we;
  logic reg_re_ff, nxt_reg_re;
  logic cfg_done_ff, nxt_cfg_done;

  logic [4:0] sync_d, sync_q;
  logic device_reset_n_s, sel0_s, sel1_s, wr_tog_s, rd_tog_s;

  logic ld_rst, ld_cs_n, ld_sclk, ld_mosi, ld_active, ld_done, ld_wr;
  logic [ADDR_W-1:0] ld_wr_addr;
  logic [BYTE_W-1:0] ld_wr_data;

  // the select straps share pins with chip select and MISO
  assign sync_d = {device_reset_n_i, csn_i, miso_i, slv_wr_tog_ff, slv_rd_tog_ff};

  bit_sync #(
    .W(5)
  ) u_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(sync_d),
    .q_o(sync_q)
  );

  assign {device_reset_n_s, sel0_s, sel1_s, wr_tog_s, rd_tog_s} = sync_q;

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_load_start = 1'b0;
    nxt_wr_seen = wr_seen_ff;
    nxt_rd_seen = rd_seen_ff;
    nxt_ack_tog = ack_tog_ff;
    nxt_rd_data = rd_data_ff;
    nxt_reg_addr = reg_addr_ff;
    nxt_reg_wdata = reg_wdata_ff;
    nxt_reg_we = 1'b0;
    nxt_reg_re = 1'b0;
    nxt_cfg_done = cfg_done_ff;
    if (reg_re_ff) begin
      nxt_rd_data = reg_rdata_i; // [R7]
      nxt_ack_tog = ~ack_tog_ff;
    end
    unique case (state_ff)
      PS_HOLD: begin
        nxt_wr_seen = wr_tog_s;
        nxt_rd_seen = rd_tog_s;
        nxt_ack_tog = 1'b0;
        if (device_reset_n_s && !device_reset_n_prev_ff) begin
          nxt_mode = host_mode_e'({sel1_s, sel0_s}); // [R1]
          unique case (host_mode_e'({sel1_s, sel0_s}))
            MODE_SPI_MASTER: begin
              nxt_state = PS_LOAD;
              nxt_load_start = 1'b1;
            end
            MODE_SPI_SLAVE: nxt_state = PS_SERVE;
            MODE_I2C_SLAVE, MODE_UNUSED: nxt_state = PS_PASSIVE; // [R8]
          endcase
        end
      end
      PS_LOAD: begin
        if (ld_wr) begin
          nxt_reg_we = 1'b1;
          nxt_reg_addr = ld_wr_addr;
          nxt_reg_wdata = ld_wr_data;
        end
        if (ld_done) begin
          nxt_state = PS_SERVE; // [R14]
          nxt_cfg_done = 1'b1;
        end
      end
      PS_SERVE: begin
        // stable link words are taken only once their toggle has crossed
        if (wr_tog_s != wr_seen_ff) begin
          nxt_wr_seen = wr_tog_s;
          nxt_reg_we = 1'b1;
          nxt_reg_addr = slv_wr_addr_ff;
          nxt_reg_wdata = slv_wr_data_ff;
        end else if (rd_tog_s != rd_seen_ff) begin
          nxt_rd_seen = rd_tog_s;
          nxt_reg_re = 1'b1;
          nxt_reg_addr = slv_rd_addr_ff;
        end
      end
      PS_PASSIVE: nxt_state = PS_PASSIVE;
    endcase
    if (!device_reset_n_s) begin
      nxt_state = PS_HOLD;
      nxt_cfg_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff <= PS_HOLD;
      mode_ff <= MODE_I2C_SLAVE;
      device_reset_n_prev_ff <= 1'b1;
      link_rst_ff <= 1'b1;
      slave_en_ff <= 1'b0;
      load_start_ff <= 1'b0;
      wr_seen_ff <= 1'b0;
      rd_seen_ff <= 1'b0;
      ack_tog_ff <= 1'b0;
      rd_data_ff <= '0;
      reg_addr_ff <= '0;
      reg_wdata_ff <= '0;
      reg_we_ff <= 1'b0;
      reg_re_ff <= 1'b0;
      cfg_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      device_reset_n_prev_ff <= device_reset_n_s;
      link_rst_ff <= (nxt_state == PS_HOLD);
      slave_en_ff <= (nxt_state == PS_SERVE);
      load_start_ff <= nxt_load_start;
      wr_seen_ff <= nxt_wr_seen;
      rd_seen_ff <= nxt_rd_seen;
      ack_tog_ff <= nxt_ack_tog;
      rd_data_ff <= nxt_rd_data;
      reg_addr_ff <= nxt_reg_addr;
      reg_wdata_ff <= nxt_reg_wdata;
      reg_we_ff <= nxt_reg_we;
      reg_re_ff <= nxt_reg_re;
      cfg_done_ff <= nxt_cfg_done;
    end
  end

  // a device reset also aborts a load in flight
  assign ld_rst = rst_i | link_rst_ff;

  eeprom_loader #(
    .CFG_BYTES(CFG_BYTES),
    .HALF_CYC(SCLK_HALF_CYC)
  ) u_loader (
    .clk_i(core_clk_i),
    .rst_i(ld_rst),
    .start_i(load_start_ff),
    .miso_i(sel1_s),
    .cs_n_o(ld_cs_n),
    .sclk_o(ld_sclk),
    .mosi_o(ld_mosi),
    .active_o(ld_active),
    .done_o(ld_done),
    .wr_o(ld_wr),
    .wr_addr_o(ld_wr_addr),
    .wr_data_o(ld_wr_data)
  );

  // link side, clocked by the external master's serial clock
  link_state_e lstate_ff, nxt_lstate;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [BYTE_W-2:0] rx_sr_ff, nxt_rx_sr;
  logic [BYTE_W-1:0] tx_sr_ff, nxt_tx_sr;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic is_read_ff, nxt_is_read;
  logic miso_ff;
  logic [BYTE_W-1:0] rx_byte;
  logic frame_rst;

  // the link clock stops between frames, so the frame ends on chip select
  assign frame_rst = csn_i | ~slave_en_ff | link_rst_ff; // [R2] [R4]

  always_comb begin
    rx_byte = {rx_sr_ff, mosi_i}; // [R6]
    nxt_lstate = lstate_ff;
    nxt_bit_cnt = bit_cnt_ff + 3'h1;
    nxt_rx_sr = rx_byte[BYTE_W-2:0];
    nxt_tx_sr = {tx_sr_ff[BYTE_W-2:0], 1'b0};
    nxt_addr = addr_ff;
    nxt_is_read = is_read_ff;
    nxt_wr_tog = slv_wr_tog_ff;
    nxt_rd_tog = slv_rd_tog_ff;
    nxt_wr_addr = slv_wr_addr_ff;
    nxt_rd_addr = slv_rd_addr_ff;
    nxt_wr_data = slv_wr_data_ff;
    nxt_ack_s1 = ack_tog_ff;
    nxt_ack_s2 = ack_s1_ff;
    if (bit_cnt_ff == 3'h7) begin
      unique case (lstate_ff)
        LS_CMD: begin
          nxt_is_read = (rx_byte == SLV_CMD_READ);
          if (rx_byte == SLV_CMD_READ || rx_byte == SLV_CMD_WRITE) begin
            nxt_lstate = LS_ADDR_HI;
          end else begin
            nxt_lstate = LS_SKIP;
          end
        end
        LS_ADDR_HI: begin
          nxt_addr = {rx_byte, addr_ff[BYTE_W-1:0]};
          nxt_lstate = LS_ADDR_LO;
        end
        LS_ADDR_LO: begin
          nxt_addr = {addr_ff[ADDR_W-1:BYTE_W], rx_byte};
          if (is_read_ff) begin
            // dummy byte gives the core time to fetch the first byte
            nxt_rd_addr = {addr_ff[ADDR_W-1:BYTE_W], rx_byte};
            nxt_rd_tog = ~slv_rd_tog_ff;
            nxt_lstate = LS_DUMMY;
          end else begin
            nxt_lstate = LS_DATA;
          end
        end
        LS_DUMMY, LS_DATA: begin
          nxt_lstate = LS_DATA;
          nxt_addr = addr_ff + ADDR_W'(1);
          if (is_read_ff) begin
            // prefetch the next byte while this one shifts out
            nxt_tx_sr = (ack_s2_ff == slv_rd_tog_ff) ? rd_data_ff : SLV_STALE_BYTE; // [R7]
            nxt_rd_addr = addr_ff + ADDR_W'(1);
            nxt_rd_tog = ~slv_rd_tog_ff;
          end else begin
            nxt_wr_addr = addr_ff;
            nxt_wr_data = rx_byte; // [R6]
            nxt_wr_tog = ~slv_wr_tog_ff;
          end
        end
        LS_SKIP: nxt_lstate = LS_SKIP;
        default: nxt_lstate = LS_SKIP;
      endcase
    end
  end

  always_ff @(posedge link_sclk_i or posedge frame_rst) begin // [R5]
    if (frame_rst) begin
      lstate_ff <= LS_CMD;
      bit_cnt_ff <= 3'h0;
      rx_sr_ff <= '0;
      tx_sr_ff <= '0;
      addr_ff <= '0;
      is_read_ff <= 1'b0;
    end else begin
      lstate_ff <= nxt_lstate;
      bit_cnt_ff <= nxt_bit_cnt;
      rx_sr_ff <= nxt_rx_sr;
      tx_sr_ff <= nxt_tx_sr;
      addr_ff <= nxt_addr;
      is_read_ff <= nxt_is_read;
    end
  end

  // toggles outlive the frame; only rst_i or a device reset clears them
  always_ff @(posedge link_sclk_i or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      slv_wr_tog_ff <= 1'b0;
      slv_rd_tog_ff <= 1'b0;
      slv_wr_addr_ff <= '0;
      slv_rd_addr_ff <= '0;
      slv_wr_data_ff <= '0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      slv_wr_tog_ff <= nxt_wr_tog;
      slv_rd_tog_ff <= nxt_rd_tog;
      slv_wr_addr_ff <= nxt_wr_addr;
      slv_rd_addr_ff <= nxt_rd_addr;
      slv_wr_data_ff <= nxt_wr_data;
      ack_s1_ff <= nxt_ack_s1;
      ack_s2_ff <= nxt_ack_s2;
    end
  end

  // launch on the falling edge, half a clock ahead of the master's sample
  always_ff @(negedge link_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      miso_ff <= 1'b0;
    end else begin
      miso_ff <= tx_sr_ff[BYTE_W-1];
    end
  end

  assign miso_o = miso_ff;
  assign miso_oe_o = ~frame_rst & is_read_ff & (lstate_ff == LS_DATA); // [R3] [R7]
  assign csn_o = ld_cs_n; // [R9]
  assign csn_oe_o = ld_active; // [R10]
  assign sclk_o = ld_sclk;
  assign sclk_oe_o = ld_active; // [R11] [R8] [R14]
  assign mosi_o = ld_mosi;
  assign mosi_oe_o = ld_active; // [R12] [R14]
  assign reg_addr_o = reg_addr_ff;
  assign reg_wdata_o = reg_wdata_ff;
  assign reg_we_o = reg_we_ff;
  assign reg_re_o = reg_re_ff;
  assign mode_o = mode_ff;
  assign mode_valid_o = (state_ff != PS_HOLD);
  assign cfg_done_o = cfg_done_ff;

endmodule
`default_nettype wire

/* File: sim/serial_host_port_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_host_port_properties
  import serial_host_pkg::*;
#(
  parameter int CFG_BYTES = CFG_BYTES_DEF,
  parameter int SCLK_HALF_CYC = EE_SCLK_HALF_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_sclk_i,
  input wire logic csn_i,
  input wire logic miso_i,
  input wire logic csn_o,
  input wire logic csn_oe_o,
  input wire logic miso_oe_o,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_o,
  input wire logic [ADDR_W-1:0] reg_addr_o,
  input wire logic reg_we_o,
  input wire logic reg_re_o,
  input wire host_mode_e mode_o,
  input wire logic mode_valid_o,
  input wire logic cfg_done_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // cycles since the driven clock last moved; the first edge of a load has no reference
  logic [7:0] hc_ff;
  logic [7:0] nxt_hc;
  logic seen_ff;
  logic nxt_seen;
  logic sclk_prev_ff;
  always_comb begin
    nxt_hc = (sclk_o != sclk_prev_ff) ? 8'h01 : hc_ff + ((hc_ff != 8'hFF) ? 8'h01 : 8'h00);
    nxt_seen = sclk_oe_o && (seen_ff || (sclk_o != sclk_prev_ff));
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hc_ff <= 8'h00;
      seen_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end else begin
      hc_ff <= nxt_hc;
      seen_ff <= nxt_seen;
      sclk_prev_ff <= sclk_o;
    end
  end

  property p_mode_capture;
    $rose(mode_valid_o) |-> 2'(mode_o) == $past({miso_i, csn_i});
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode differs from pins");
  property p_csn_drive;
    csn_oe_o |-> !csn_o && mode_o == MODE_SPI_MASTER && !cfg_done_o;
  endproperty
  a_csn_drive: assert property (p_csn_drive) else $error("chip select drive wrong");
  property p_oe_group;
    sclk_oe_o == csn_oe_o && mosi_oe_o == csn_oe_o;
  endproperty
  a_oe_group: assert property (p_oe_group) else $error("master enables differ");
  property p_half_period;
    sclk_oe_o && seen_ff && sclk_o != sclk_prev_ff |-> hc_ff == 8'(SCLK_HALF_CYC);
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock half period");
  property p_mosi_on_fall;
    sclk_oe_o && $past(sclk_oe_o) && $changed(mosi_o) |-> $fell(sclk_o);
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("mosi moved off fall");
  property p_release;
    $fell(csn_oe_o) && mode_valid_o |-> ##[1:3] cfg_done_o;
  endproperty
  a_release: assert property (p_release) else $error("load end without done");
  property p_done_quiet;
    cfg_done_o |-> !csn_oe_o && !sclk_oe_o && !mosi_oe_o;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("pin driven after load");
  property p_miso_drive;
    miso_oe_o |-> mode_valid_o && !csn_oe_o && (mode_o == MODE_SPI_SLAVE || cfg_done_o);
  endproperty
  a_miso_drive: assert property (p_miso_drive) else $error("miso driven off slave");
  property p_read_mode;
    reg_re_o |-> mode_o == MODE_SPI_SLAVE || cfg_done_o;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("read outside slave mode");
  property p_passive;
    mode_valid_o && (mode_o == MODE_I2C_SLAVE || mode_o == MODE_UNUSED)
      |-> !(csn_oe_o || sclk_oe_o || mosi_oe_o || miso_oe_o);
  endproperty
  a_passive: assert property (p_passive) else $error("pin driven in passive mode");
  property p_cfg_addr;
    reg_we_o && mode_o == MODE_SPI_MASTER && !cfg_done_o |-> reg_addr_o < ADDR_W'(CFG_BYTES);
  endproperty
  a_cfg_addr: assert property (p_cfg_addr) else $error("load write address range");
  c_slave_read: cover property (@(posedge link_sclk_i) disable iff (rst_i) !csn_i && miso_oe_o);
endmodule
bind serial_host_port serial_host_port_properties #(
  .CFG_BYTES(CFG_BYTES),
  .SCLK_HALF_CYC(SCLK_HALF_CYC)
) chk_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .link_sclk_i(link_sclk_i), .csn_i(csn_i),
  .miso_i(miso_i), .csn_o(csn_o), .csn_oe_o(csn_oe_o), .miso_oe_o(miso_oe_o),
  .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
  .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o), .mode_o(mode_o),
  .mode_valid_o(mode_valid_o), .cfg_done_o(cfg_done_o)
);
`default_nettype wire

/* File: sim/spi_eeprom_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_model (
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic [7:0] base_i,
  output logic miso_o,
  output logic [23:0] hdr_o
);
  int bit_cnt;
  int idx;
  logic [7:0] cur;
  initial begin
    bit_cnt = 0;
    hdr_o = 24'h000000;
    miso_o = 1'b0;
  end
  always @(negedge cs_n_i) bit_cnt = 0;
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (bit_cnt < 24) hdr_o = {hdr_o[22:0], mosi_i};
      bit_cnt = bit_cnt + 1;
    end
  end
  // data moves on the fall, so it is steady through the high half
  always @(negedge sclk_i) begin
    if (!cs_n_i && bit_cnt >= 24) begin
      idx = bit_cnt - 24;
      cur = base_i + hdr_o[7:0] + 8'(idx / 8);
      miso_o = cur[7 - (idx % 8)];
    end
  end
  // no pull on the line: a released pin must not keep looking valid
  always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule
`default_nettype wire

/* File: sim/tb_serial_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_host_port
  import serial_host_pkg::*;
;
  localparam int NB = 2;
  localparam int HC = 3;
  logic clk, rst, dev_rst_n, strap_en, bench_cs_n, sclk_b, mosi_b;
  logic [1:0] strap;
  logic [7:0] base, rdata, wdata;
  logic csn_d, csn_oe, miso_d, miso_oe, sclk_d, sclk_oe, mosi_d, mosi_oe, we, re, mvalid, cdone;
  logic cs_n_pin, miso_pin, sclk_pin, mosi_pin, ee_miso;
  logic [15:0] raddr;
  logic [23:0] hdr;
  host_mode_e mode;
  int errors, n_tests, seed;
  logic [23:0] wq[$];
  logic [15:0] rq[$];
  logic [7:0] dbuf[2];
  logic [7:0] rbuf[2];

  function automatic logic [7:0] rd_fn(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  assign cs_n_pin = csn_oe ? csn_d : (strap_en ? strap[0] : bench_cs_n);
  assign miso_pin = miso_oe ? miso_d : (strap_en ? strap[1] : ee_miso);
  assign sclk_pin = sclk_oe ? sclk_d : sclk_b;
  assign mosi_pin = mosi_oe ? mosi_d : mosi_b;
  assign rdata = rd_fn(raddr);

  serial_host_port #(.CFG_BYTES(NB), .SCLK_HALF_CYC(HC)) dut_u (
    .core_clk_i(clk), .rst_i(rst), .link_sclk_i(sclk_pin), .device_reset_n_i(dev_rst_n),
    .csn_i(cs_n_pin), .csn_o(csn_d), .csn_oe_o(csn_oe), .miso_i(miso_pin), .miso_o(miso_d),
    .miso_oe_o(miso_oe), .sclk_o(sclk_d), .sclk_oe_o(sclk_oe), .mosi_i(mosi_pin),
    .mosi_o(mosi_d), .mosi_oe_o(mosi_oe), .reg_addr_o(raddr), .reg_wdata_o(wdata),
    .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(rdata), .mode_o(mode),
    .mode_valid_o(mvalid), .cfg_done_o(cdone)
  );
  spi_eeprom_model ee_u (
    .cs_n_i(cs_n_pin), .sclk_i(sclk_pin), .mosi_i(mosi_pin), .base_i(base),
    .miso_o(ee_miso), .hdr_o(hdr)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (we === 1'b1) wq.push_back({raddr, wdata});
  always @(posedge clk) if (re === 1'b1) rq.push_back(raddr);

  task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // straps are held well past the sync delay on both sides of the release
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    strap <= m;
    strap_en <= 1'b1;
    dev_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    dev_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    strap_en <= 1'b0;
    chk_bit("mode_valid", 1'b1, mvalid);
    chk_val("mode", 24'(m), 24'(mode));
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_b = tx[i];
      #15 sclk_b = 1'b1;
      rx[i] = miso_pin;
      #15 sclk_b = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [15:0] a);
    logic [7:0] rx;
    @(posedge clk);
    #1.3 bench_cs_n = 1'b0;
    #15;
    spi_byte(cmd, rx);
    spi_byte(a[15:8], rx);
    spi_byte(a[7:0], rx);
    if (cmd == SLV_CMD_READ) spi_byte(8'h00, rx);
    for (int j = 0; j < 2; j++) begin
      spi_byte(dbuf[j], rx);
      rbuf[j] = rx;
    end
    #15 bench_cs_n = 1'b1;
    mosi_b = ~mosi_b;
  endtask
  task automatic slave_traffic(input logic [15:0] aw, input logic [15:0] ar);
    for (int j = 0; j < 2; j++) dbuf[j] = 8'($random(seed));
    wq.delete();
    frame(SLV_CMD_WRITE, aw);
    repeat (10) @(posedge clk);
    chk_val("wr_count", 24'd2, 24'(wq.size()));
    for (int j = 0; j < 2; j++) chk_val("wr", {aw + 16'(j), dbuf[j]}, wq[j]);
    rq.delete();
    frame(SLV_CMD_READ, ar);
    for (int j = 0; j < 2; j++) chk_val("rd", 24'(rd_fn(ar + 16'(j))), 24'(rbuf[j]));
    repeat (4) @(posedge clk);
    #1 chk_bit("miso_oe_idle", 1'b0, miso_oe);
    // address, dummy end and both data ends each ask for one byte
    chk_val("rd_req_count", 24'd4, 24'(rq.size()));
    chk_val("rd_req", {8'h0, ar}, {8'h0, rq[0]});
    // unknown command: the rest of the frame must be ignored
    wq.delete();
    frame(8'hA5, aw);
    repeat (10) @(posedge clk);
    chk_val("skip_count", 24'd0, 24'(wq.size()));
  endtask

  initial begin
    seed = 32'h7e5b560c;
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    dev_rst_n = 1'b0;
    strap_en = 1'b1;
    strap = 2'h0;
    bench_cs_n = 1'b1;
    sclk_b = 1'b0;
    mosi_b = 1'b0;
    base = 8'($random(seed));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 4; m += 3) begin
      set_mode(2'(m));
      repeat (20) @(posedge clk);
      #1 chk_bit("passive", 1'b0, csn_oe | sclk_oe | mosi_oe | miso_oe);
    end
    wq.delete();
    set_mode(2'h2);
    for (int i = 0; i < 2000 && cdone !== 1'b1; i++) @(posedge clk);
    #1 chk_bit("cfg_done", 1'b1, cdone);
    chk_val("header", {EE_CMD_READ, EE_START_ADDR}, hdr);
    chk_val("cfg_count", 24'(NB), 24'(wq.size()));
    for (int k = 0; k < NB; k++) chk_val("cfg", {16'(k), base + 8'(k)}, wq[k]);
    chk_bit("released", 1'b0, csn_oe | sclk_oe | mosi_oe);
    slave_traffic(16'hFFFF, 16'($random(seed)));
    set_mode(2'h1);
    slave_traffic(16'($random(seed)), 16'hFFFF);
    set_mode(2'h2);
    repeat (60) @(posedge clk);
    #1 chk_bit("loading", 1'b1, csn_oe);
    chk_bit("select_low", 1'b0, cs_n_pin);
    dev_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk_bit("abort", 1'b0, csn_oe | sclk_oe | mosi_oe);
    chk_bit("abort_done", 1'b0, cdone);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    end_of_test;
  end
endmodule
`default_nettype wire
